// *** rtl/epil_pkg.sv ***
// Package of register offsets, field layouts and reset values for the external pin interrupt logic.
// What this block does
// [RL1] Falling edge on nmi pin requests nmi.
// [RL2] Nmi is highest priority, ignores mask bit.
// [RL3] Request 3 polarity bit: 0 falling, 1 rising.
// [RL4] Request 0 polarity bit: 0 falling, 1 rising.
// [RL5] Edge register reserved bits read 0,111,00.
// [RL6] Four request pins, distinct vectors, independent detection.
// [RL7] Enabled request pin edge sets pending flag.
// [RL8] Accepting request interrupt sets cpu mask bit.
// [RL9] Each request pin has own enable bit.
// [RL10] Six wakeup pins share vector, own polarity.
// [RL11] Enabled wakeup pin edge sets wakeup flag.
// [RL12] One group enable masks all wakeup pins.
// [RL13] Flags stay set until software writes zero.
package epil_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EPIL_OFS_EDGE1  = 8'h00;
  localparam logic [7:0] EPIL_OFS_EDGE2  = 8'h04;
  localparam logic [7:0] EPIL_OFS_ENABLE = 8'h08;
  localparam logic [7:0] EPIL_OFS_REQFLG = 8'h0c;
  localparam logic [7:0] EPIL_OFS_WKPFLG = 8'h10;
  localparam logic [7:0] EPIL_OFS_REQFN  = 8'h14;
  localparam logic [7:0] EPIL_OFS_WKPFN  = 8'h18;
  localparam logic [7:0] EPIL_OFS_STATUS = 8'h1c;
  localparam logic [7:0] EPIL_OFS_MASK   = 8'h20;
  localparam logic [7:0] EPIL_OFS_CCR    = 8'h24;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int EPIL_NREQ = 4;
  localparam int EPIL_NWKP = 6;
  localparam int EPIL_BIT_REQ3 = 3;
  localparam int EPIL_BIT_REQ0 = 0;
  localparam int EPIL_BIT_WKEN = 5;
  localparam int EPIL_BIT_IMASK = 7;
  localparam logic [7:0] EPIL_EDGE1_WMASK = 8'h09;
  localparam logic [7:0] EPIL_EDGE1_FIXED = 8'h70;
  localparam logic [7:0] EPIL_ENABLE_WMASK = 8'h2f;
  localparam int EPIL_ST_NMI = 0;
  localparam int EPIL_ST_REQ = 1;
  localparam int EPIL_ST_WKP = 2;
  localparam int EPIL_NST = 3;

  // ----------------------------------------------------------------
  // Reset values and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] EPIL_RST_BYTE = 8'h00;
  localparam logic [1:0] EPIL_RESP_OKAY = 2'b00;
  localparam logic [1:0] EPIL_RESP_SLVERR = 2'b10;

  // Interrupt source codes presented to the core.
  typedef enum logic [2:0] {
    EPIL_VEC_NONE = 3'b000,
    EPIL_VEC_NMI  = 3'b001,
    EPIL_VEC_REQ0 = 3'b010,
    EPIL_VEC_REQ1 = 3'b011,
    EPIL_VEC_REQ2 = 3'b100,
    EPIL_VEC_REQ3 = 3'b101,
    EPIL_VEC_WKP  = 3'b110
  } epil_vec_e;

endpackage

// *** rtl/epil_edge_det.sv ***
// Synchroniser and selectable edge detector for a group of pins.
module epil_edge_det #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] rise_sel_i,
  output logic      [WIDTH-1:0] edge_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } epil_det_s;

  epil_det_s s_q;
  epil_det_s s_d;

  // ----------------------------------------------------------------
  // Synchroniser and previous level
  // ----------------------------------------------------------------
  // Pins idle high; resetting to ones avoids a false falling edge after reset.
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Edge select
  // ----------------------------------------------------------------
  // A one in rise_sel picks the rising edge, a zero the falling edge.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      edge_o[i] = rise_sel_i[i] ? (s_q.sync[i] & ~s_q.last[i]) : (~s_q.sync[i] & s_q.last[i]);
    end
  end

endmodule

// *** rtl/epil_top.sv ***
// External pin interrupt logic with an AXI4-Lite register slave.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
module epil_top
  import epil_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  nmi_n_i,
  input  wire logic [EPIL_NREQ-1:0]  req_pin_i,
  input  wire logic [EPIL_NWKP-1:0]  wakeup_pin_i,
  input  wire logic                  int_ack_i,
  input  wire logic [2:0]            ack_vec_i,
  output logic                       int_req_o,
  output epil_pkg::epil_vec_e        int_vec_o,
  output logic                       nmi_req_o,
  output logic                       cpu_imask_o,
  output logic                       irq_o,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  import epil_pkg::*;

  typedef struct packed {
    logic                 aw_held;
    logic [7:0]           aw_addr;
    logic                 w_held;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [7:0]           edge1;
    logic [EPIL_NWKP-1:0] edge2;
    logic [7:0]           enable;
    logic [EPIL_NREQ-1:0] req_flag;
    logic [EPIL_NWKP-1:0] wkp_flag;
    logic [EPIL_NREQ-1:0] req_fn;
    logic [EPIL_NWKP-1:0] wkp_fn;
    logic                 nmi_pend;
    logic                 imask;
    logic [EPIL_NST-1:0]  status;
    logic [EPIL_NST-1:0]  mask;
    logic                 int_req;
    epil_vec_e            vec;
    logic                 nmi_req;
  } epil_s;

  epil_s s_q;
  epil_s s_d;

  logic [EPIL_NREQ-1:0] req_edge;
  logic [EPIL_NWKP-1:0] wkp_edge;
  logic [0:0]           nmi_edge;
  logic [EPIL_NREQ-1:0] req_rise_sel;

  // Only polarity bits for pins 3 and 0 exist; pins 2 and 1 stay falling.
  assign req_rise_sel = {s_q.edge1[EPIL_BIT_REQ3], 2'b00, s_q.edge1[EPIL_BIT_REQ0]}; // [RL3] [RL4]

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  epil_edge_det #(.WIDTH(1)) u_nmi_det (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (nmi_n_i),
    .rise_sel_i (1'b0),
    .edge_o     (nmi_edge)
  ); // [RL1]

  epil_edge_det #(.WIDTH(EPIL_NREQ)) u_req_det (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (req_pin_i),
    .rise_sel_i (req_rise_sel),
    .edge_o     (req_edge)
  ); // [RL6]

  epil_edge_det #(.WIDTH(EPIL_NWKP)) u_wkp_det (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (wakeup_pin_i),
    .rise_sel_i (s_q.edge2),
    .edge_o     (wkp_edge)
  ); // [RL10]

  // Merges a written byte into a register under a writable-bit mask.
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] nv, input logic [7:0] wm);
    wr_byte = (old & ~wm) | (nv & wm);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                 wr_go;
  logic                 wr_hit;
  logic [7:0]           wb;
  logic [EPIL_NREQ-1:0] req_active;
  logic                 wkp_active;
  logic [EPIL_NST-1:0]  ev;
  logic [7:0]           rd_byte;
  logic                 rd_hit;

  always_comb begin
    s_d        = s_q;
    wr_go      = 1'b0;
    wr_hit     = 1'b1;
    wb         = s_q.w_data[7:0];
    rd_byte    = EPIL_RST_BYTE;
    rd_hit     = 1'b1;
    req_active = '0;
    wkp_active = 1'b0;
    ev         = '0;

    // Address and data channels are taken independently and held.
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Flags are sticky; the edge set is applied after the software clear so the set wins.
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      wr_go       = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (s_q.w_strb[0]) begin
        case (s_q.aw_addr)
          EPIL_OFS_EDGE1:  s_d.edge1 = wr_byte(s_q.edge1, wb, EPIL_EDGE1_WMASK);
          EPIL_OFS_EDGE2:  s_d.edge2 = wb[EPIL_NWKP-1:0];
          EPIL_OFS_ENABLE: s_d.enable = wr_byte(s_q.enable, wb, EPIL_ENABLE_WMASK);
          EPIL_OFS_REQFLG: s_d.req_flag = s_q.req_flag & wb[EPIL_NREQ-1:0]; // [RL13]
          EPIL_OFS_WKPFLG: s_d.wkp_flag = s_q.wkp_flag & wb[EPIL_NWKP-1:0]; // [RL13]
          EPIL_OFS_REQFN:  s_d.req_fn = wb[EPIL_NREQ-1:0];
          EPIL_OFS_WKPFN:  s_d.wkp_fn = wb[EPIL_NWKP-1:0];
          EPIL_OFS_STATUS: s_d.status = s_q.status & ~wb[EPIL_NST-1:0];
          EPIL_OFS_MASK:   s_d.mask = wb[EPIL_NST-1:0];
          EPIL_OFS_CCR:    s_d.imask = wb[EPIL_BIT_IMASK];
          default:         wr_hit = 1'b0;
        endcase
      end else begin
        case (s_q.aw_addr)
          EPIL_OFS_EDGE1, EPIL_OFS_EDGE2, EPIL_OFS_ENABLE, EPIL_OFS_REQFLG, EPIL_OFS_WKPFLG,
          EPIL_OFS_REQFN, EPIL_OFS_WKPFN, EPIL_OFS_STATUS, EPIL_OFS_MASK, EPIL_OFS_CCR: wr_hit = 1'b1;
          default: wr_hit = 1'b0;
        endcase
      end
      s_d.bresp = wr_hit ? EPIL_RESP_OKAY : EPIL_RESP_SLVERR;
    end

    // Pin events set pending flags only when the pin works as an interrupt input.
    s_d.req_flag = s_d.req_flag | (req_edge & s_q.req_fn); // [RL7]
    s_d.wkp_flag = s_d.wkp_flag | (wkp_edge & s_q.wkp_fn); // [RL11]
    if (nmi_edge[0]) begin
      s_d.nmi_pend = 1'b1; // [RL1]
    end

    ev[EPIL_ST_NMI] = nmi_edge[0];
    ev[EPIL_ST_REQ] = |(req_edge & s_q.req_fn);
    ev[EPIL_ST_WKP] = |(wkp_edge & s_q.wkp_fn);
    s_d.status = s_d.status | ev;

    // Core acceptance: any accepted source code (nmi, request or wakeup) sets the mask bit; flags stay for software.
    if (int_ack_i && s_q.int_req) begin
      if (ack_vec_i == EPIL_VEC_NMI) begin
        // A fresh edge in the acceptance cycle stays pending, so the set wins.
        s_d.nmi_pend = nmi_edge[0];
      end
      if (ack_vec_i != EPIL_VEC_NONE) begin
        s_d.imask = 1'b1; // [RL8]
      end
    end

    // Priority: nmi first regardless of the mask, then request 0..3, then wakeup group.
    req_active = s_d.req_flag & s_q.enable[EPIL_NREQ-1:0]; // [RL9]
    wkp_active = (|s_d.wkp_flag) & s_q.enable[EPIL_BIT_WKEN]; // [RL12]
    s_d.nmi_req = s_d.nmi_pend;
    s_d.int_req = 1'b0;
    s_d.vec     = EPIL_VEC_NONE;
    if (s_d.nmi_pend) begin
      s_d.int_req = 1'b1; // [RL2]
      s_d.vec     = EPIL_VEC_NMI;
    end else if (!s_d.imask) begin
      if (req_active[0]) begin
        s_d.int_req = 1'b1; // [RL6]
        s_d.vec     = EPIL_VEC_REQ0;
      end else if (req_active[1]) begin
        s_d.int_req = 1'b1;
        s_d.vec     = EPIL_VEC_REQ1;
      end else if (req_active[2]) begin
        s_d.int_req = 1'b1;
        s_d.vec     = EPIL_VEC_REQ2;
      end else if (req_active[3]) begin
        s_d.int_req = 1'b1;
        s_d.vec     = EPIL_VEC_REQ3;
      end else if (wkp_active) begin
        s_d.int_req = 1'b1; // [RL10]
        s_d.vec     = EPIL_VEC_WKP;
      end
    end

    // Read channel.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      case (s_axi_araddr)
        EPIL_OFS_EDGE1:  rd_byte = (s_q.edge1 & EPIL_EDGE1_WMASK) | EPIL_EDGE1_FIXED; // [RL5]
        EPIL_OFS_EDGE2:  rd_byte = {2'b00, s_q.edge2};
        EPIL_OFS_ENABLE: rd_byte = s_q.enable;
        EPIL_OFS_REQFLG: rd_byte = {4'h0, s_q.req_flag};
        EPIL_OFS_WKPFLG: rd_byte = {2'b00, s_q.wkp_flag};
        EPIL_OFS_REQFN:  rd_byte = {4'h0, s_q.req_fn};
        EPIL_OFS_WKPFN:  rd_byte = {2'b00, s_q.wkp_fn};
        EPIL_OFS_STATUS: rd_byte = {5'h00, s_q.status};
        EPIL_OFS_MASK:   rd_byte = {5'h00, s_q.mask};
        EPIL_OFS_CCR:    rd_byte = {s_q.imask, 7'h00};
        default:         rd_hit = 1'b0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h00_0000, rd_byte};
      s_d.rresp  = rd_hit ? EPIL_RESP_OKAY : EPIL_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.edge1 <= EPIL_EDGE1_FIXED;
      s_q.vec   <= EPIL_VEC_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready  = !s_q.w_held;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign int_req_o     = s_q.int_req;
  assign int_vec_o     = s_q.vec;
  assign nmi_req_o     = s_q.nmi_req;
  assign cpu_imask_o   = s_q.imask;
  assign irq_o         = |(s_q.status & s_q.mask);

endmodule

// *** tb/epil_sva.sv ***
// Port-level checker for the external pin interrupt logic.
module epil_sva
  import epil_pkg::*;
(
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic                int_ack_i,
  input wire logic [2:0]          ack_vec_i,
  input wire logic                int_req_o,
  input wire epil_pkg::epil_vec_e int_vec_o,
  input wire logic                nmi_req_o,
  input wire logic                cpu_imask_o,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  chk_nmi_code: assert property (nmi_req_o |-> int_req_o && int_vec_o == EPIL_VEC_NMI)
    else $error("nmi pending without nmi code");
  chk_nmi_hold: assert property (nmi_req_o && !(int_ack_i && ack_vec_i == 3'h1) |=> nmi_req_o)
    else $error("nmi request dropped without acceptance");
  chk_ack_mask: assert property (int_ack_i && int_req_o && ack_vec_i != 3'h0 |=> cpu_imask_o)
    else $error("accepted request did not set cpu mask");
  // The mask bit is checked over two cycles; the source code is registered from the same next mask bit.
  chk_req_blocked: assert property (cpu_imask_o && $past(cpu_imask_o) |->
    !(int_vec_o inside {EPIL_VEC_REQ0, EPIL_VEC_REQ1, EPIL_VEC_REQ2, EPIL_VEC_REQ3}))
    else $error("request pin passed while cpu mask set");
  chk_code_idle: assert property (!int_req_o |-> int_vec_o == EPIL_VEC_NONE)
    else $error("source code shown without request");

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn early");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn early");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  cov_nmi: cover property (nmi_req_o ##1 !nmi_req_o);
  cov_ack: cover property (int_ack_i && int_req_o);
  cov_wkp: cover property (int_vec_o == EPIL_VEC_WKP);
endmodule

// *** tb/epil_cpu_model.sv ***
// Behavioural model of the core's interrupt acceptance.
module epil_cpu_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       int_req_i,
  input  wire logic [2:0] int_vec_i,
  output logic            int_ack_o,
  output logic [2:0]      ack_vec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;

  // A request must stand delay_i+1 cycles before it is accepted, so slow cores are covered too.
  // The code lines hold a non-source value between acceptances to catch unqualified use.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !en_i || !int_req_i || int_ack_o) begin
      cnt_q     <= 4'h0;
      int_ack_o <= 1'b0;
      ack_vec_o <= 3'h7;
    end else if (cnt_q == delay_i) begin
      int_ack_o <= 1'b1;
      ack_vec_o <= int_vec_i;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// *** tb/external_pin_interrupt_logic_tb.sv ***
// Register-level testbench for the external pin interrupt logic.
module external_pin_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import epil_pkg::*;
  logic        core_clk_i, rst_i, nmi_n_i, int_ack_i, int_req_o, nmi_req_o, cpu_imask_o, irq_o, m_en;
  logic [3:0]  req_pin_i, s_axi_wstrb, m_dly;
  logic [5:0]  wakeup_pin_i;
  logic [2:0]  ack_vec_i;
  epil_vec_e   int_vec_o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_fail = 0;
  int          n_checks = 0;

  epil_top u_dut (.*);
  epil_cpu_model u_cpu (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .en_i       (m_en),
    .delay_i    (m_dly),
    .int_req_i  (int_req_o),
    .int_vec_i  (int_vec_o),
    .int_ack_o  (int_ack_i),
    .ack_vec_o  (ack_vec_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Handshakes are judged right after each rising edge, on the values which that edge sampled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = EPIL_RESP_OKAY);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    repeat (30) begin
      @(posedge core_clk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w  = s_axi_wvalid & s_axi_wready;
      b  = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, rs}, {30'h0, er});
        return;
      end else if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end
    n_fail++;
    tally_and_finish();
  endtask

  // Ready rises a cycle late so the slave must hold its answer.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = EPIL_RESP_OKAY);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    repeat (30) begin
      @(posedge core_clk_i);
      ar = s_axi_arvalid & s_axi_arready;
      r  = s_axi_rvalid & s_axi_rready;
      d  = s_axi_rdata;
      rs = s_axi_rresp;
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) begin
        s_axi_rready <= 1'b0;
        chk(d, e);
        chk({30'h0, rs}, {30'h0, er});
        return;
      end else if (!s_axi_arvalid) s_axi_rready <= 1'b1;
    end
    n_fail++;
    tally_and_finish();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  // Pins pass a two-stage synchroniser and a compare stage before any flag moves.
  task automatic pins(input logic [3:0] r, input logic [5:0] w);
    @(posedge core_clk_i);
    req_pin_i    <= r;
    wakeup_pin_i <= w;
    cyc(6);
  endtask

  task automatic wt(input int k);
    repeat (40) begin
      @(negedge core_clk_i);
      if (k == 0 ? cpu_imask_o === 1'b1 : nmi_req_o === 1'b0) return;
    end
    n_fail++;
    tally_and_finish();
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    nmi_n_i = 1'b1;
    req_pin_i = 4'hf;
    wakeup_pin_i = 6'h3f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hf;
    m_en = 1'b0;
    m_dly = 4'h3;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cyc(3);
    rd(EPIL_OFS_EDGE1, 32'h0000_0070);
    wr(EPIL_OFS_EDGE1, 32'hffff_ffff);
    rd(EPIL_OFS_EDGE1, 32'h0000_0079);
    rd(8'h3c, 32'h0000_0000, EPIL_RESP_SLVERR);
    wr(8'h3c, 32'h0000_0001, EPIL_RESP_SLVERR);
    wr(EPIL_OFS_EDGE1, 32'h0000_0008);
    wr(EPIL_OFS_REQFN, 32'h0000_000f);
    wr(EPIL_OFS_MASK, 32'h0000_0007);
    pins(4'h6, 6'h3f);
    rd(EPIL_OFS_REQFLG, 32'h0000_0001);
    pins(4'hf, 6'h3f);
    rd(EPIL_OFS_REQFLG, 32'h0000_0009);
    cyc(1);
    chk({31'h0, int_req_o}, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(EPIL_OFS_ENABLE, 32'h0000_0008);
    cyc(2);
    chk({29'h0, int_vec_o}, {29'h0, EPIL_VEC_REQ3});
    wr(EPIL_OFS_ENABLE, 32'h0000_000f);
    cyc(2);
    chk({29'h0, int_vec_o}, {29'h0, EPIL_VEC_REQ0});
    wr(EPIL_OFS_REQFLG, 32'h0000_0008);
    rd(EPIL_OFS_REQFLG, 32'h0000_0008);
    m_en <= 1'b1;
    wt(0);
    chk({31'h0, cpu_imask_o}, 32'h0000_0001);
    m_en <= 1'b0;
    cyc(3);
    chk({31'h0, int_req_o}, 32'h0000_0000);
    @(posedge core_clk_i) nmi_n_i <= 1'b0;
    cyc(6);
    chk({29'h0, int_vec_o}, {29'h0, EPIL_VEC_NMI});
    m_en <= 1'b1;
    wt(1);
    m_en <= 1'b0;
    @(posedge core_clk_i) nmi_n_i <= 1'b1;
    rd(EPIL_OFS_STATUS, 32'h0000_0003);
    wr(EPIL_OFS_STATUS, 32'h0000_0003);
    cyc(1);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wr(EPIL_OFS_REQFLG, 32'h0000_0000);
    wr(EPIL_OFS_CCR, 32'h0000_0000);
    wr(EPIL_OFS_REQFN, 32'h0000_0000);
    pins(4'hd, 6'h3f);
    rd(EPIL_OFS_REQFLG, 32'h0000_0000);
    wr(EPIL_OFS_WKPFN, 32'h0000_003f);
    wr(EPIL_OFS_EDGE2, 32'h0000_0001);
    wr(EPIL_OFS_ENABLE, 32'h0000_0000);
    pins(4'hf, 6'h1e);
    rd(EPIL_OFS_WKPFLG, 32'h0000_0020);
    pins(4'hf, 6'h3f);
    rd(EPIL_OFS_WKPFLG, 32'h0000_0021);
    cyc(1);
    chk({31'h0, int_req_o}, 32'h0000_0000);
    wr(EPIL_OFS_ENABLE, 32'h0000_0020);
    cyc(2);
    chk({29'h0, int_vec_o}, {29'h0, EPIL_VEC_WKP});
    tally_and_finish();
  end
endmodule

bind epil_top epil_sva u_sva (.*);
